// *** include/rco_pkg.sv ***
// Constants, register layout and carrier types for the reference clock output block.
// Assumes a single 25 MHz system clock and an APB register bus with 32-bit data.
package rco_pkg;

    // ==========================================================================
    // Register map. Printed offsets are indices; byte address is four times each.
    localparam logic [15:0] RCO_CTRL_INDEX   = 16'h0F39;
    localparam logic [15:0] RCO_SRCSEL_INDEX = 16'h0F3A;
    localparam logic [15:0] RCO_CTRL_ADDR    = 16'(RCO_CTRL_INDEX * 4);
    localparam logic [15:0] RCO_SRCSEL_ADDR  = 16'(RCO_SRCSEL_INDEX * 4);

    // ==========================================================================
    // Field positions within the control and source-select registers.
    localparam int RCO_EN_BIT     = 7;
    localparam int RCO_DUTY_LSB   = 3;
    localparam int RCO_RATIO_LSB  = 0;
    localparam int RCO_SRC_LSB    = 0;

    // ==========================================================================
    // Values after reset.
    localparam logic       RCO_EN_RST    = 1'b0;
    localparam logic [1:0] RCO_DUTY_RST  = 2'h2;
    localparam logic [2:0] RCO_RATIO_RST = 3'h0;
    localparam logic [3:0] RCO_SRC_RST   = 4'h0;

    // ==========================================================================
    // Source codes and counts.
    localparam logic [3:0] RCO_SRC_SYSTEM_OSC = 4'h0;
    localparam logic [3:0] RCO_SRC_SECONDARY  = 4'h4;
    localparam logic [3:0] RCO_SRC_LC_FIRST   = 4'h8;
    localparam int         RCO_NUM_SOURCES    = 13;
    localparam int         RCO_SYNC_STAGES    = 2;

    // Control register contents.
    typedef struct packed {
        logic       enable;
        logic [1:0] duty_select;
        logic [2:0] ratio;
    } rco_ctrl_s;

    // Clock sources as they arrive from the oscillators and logic cells.
    typedef struct packed {
        logic [7:0] logic_cell_output;
        logic       secondary_oscillator;
        logic       mid_internal_oscillator;
        logic       low_internal_oscillator;
        logic       high_internal_oscillator;
        logic       system_oscillator_clock;
    } rco_src_s;

    // Output sequencer states, Gray coded along idle, armed, running.
    typedef enum logic [1:0] {
        RCO_IDLE = 2'b00,
        RCO_ARM  = 2'b01,
        RCO_RUN  = 2'b11
    } rco_state_e;

endpackage

// *** hdl/rco_top.sv ***
// Reference clock output: source select, power-of-two divider and duty shaping.
// Assumes asynchronous clock sources, sampled through two flip-flops at 25 MHz,
// each well below half the system clock rate, and an APB master on the same clock.
//
// What this block does
// (R1) Four-bit code selects the source clock.
// (R2) Enabling starts output cleanly, no runt pulse.
// (R3) Disabling stops the output immediately.
// (R4) Software changes divider and duty only disabled; the block also accepts these writes while enabled.
// (R5) Divide source by two to the ratio.
// (R6) Duty code gives 0, 25, 50, 75 percent.
// (R7) Ratio zero: 50 percent, or low for zero.
// (R8) Duty field resets to binary 10.
// (R9) Halt stops only the system oscillator source.
// (R10) Generated clock also routed to internal peripherals.
// (R11) Control: enable bit 7, duty 4:3, ratio 2:0.
// (R12) Source select in bits 3:0, reset zero.
// (R13) Undocumented source codes hold the output low.
// (R14) Count edges; high for leading duty fraction.
//
// The APB register port was left to the implementer.
`timescale 1ns/100ps

module rco_top (
    // Clock and reset.
    input  wire logic              clock,
    input  wire logic              rstn,
    // APB slave.
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [15:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Clock sources and power state.
    input  wire rco_pkg::rco_src_s clock_sources,
    input  wire logic              low_power_halt,
    // Reference clock to the pin and to internal consumers.
    output logic                   reference_output_pin,
    output logic                   reference_output_oe_n,
    output logic                   reference_clock_internal
);
    import rco_pkg::*;

    // ==========================================================================
    // Reset release.

    logic [1:0]                 rst_sync_reg;
    logic                       rst_n;

    // Reset asserts at once but releases only after two clean edges.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // ==========================================================================
    // Registers and APB slave.

    rco_ctrl_s                  ctrl_reg;
    logic [3:0]                 src_sel_reg;
    logic [31:0]                prdata_reg;
    logic                       pready_reg;
    logic                       pslverr_reg;
    logic                       hit_ctrl;
    logic                       hit_src;
    logic                       write_now;

    assign hit_ctrl  = (paddr == RCO_CTRL_ADDR);
    assign hit_src   = (paddr == RCO_SRCSEL_ADDR);
    assign write_now = psel && penable && pready_reg && pwrite;

    // Answer is prepared in the setup cycle so that every bus output is a flop.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prdata_reg  <= 32'h0000_0000;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else if (psel && !penable) begin
            pready_reg  <= 1'b1;
            pslverr_reg <= !(hit_ctrl || hit_src);
            if (hit_ctrl && !pwrite) begin
                prdata_reg <= {24'h00_0000, ctrl_reg.enable, 2'b00,
                               ctrl_reg.duty_select, ctrl_reg.ratio};
            end else if (hit_src && !pwrite) begin
                prdata_reg <= {28'h000_0000, src_sel_reg};
            end else begin
                prdata_reg <= 32'h0000_0000;
            end
        end else begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end
    end

    // Control register. Live changes are accepted; glitch avoidance is software's job.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg.enable      <= RCO_EN_RST;
            ctrl_reg.duty_select <= RCO_DUTY_RST; // R8
            ctrl_reg.ratio       <= RCO_RATIO_RST;
        end else if (write_now && hit_ctrl) begin
            ctrl_reg.enable      <= pwdata[RCO_EN_BIT];          // R11
            ctrl_reg.duty_select <= pwdata[RCO_DUTY_LSB +: 2];   // R11
            ctrl_reg.ratio       <= pwdata[RCO_RATIO_LSB +: 3];  // R11 R4
        end
    end

    // Source select register.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            src_sel_reg <= RCO_SRC_RST; // R12
        end else if (write_now && hit_src) begin
            src_sel_reg <= pwdata[RCO_SRC_LSB +: 4]; // R12
        end
    end

    assign prdata  = prdata_reg;
    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;

    // ==========================================================================
    // Source synchronisation and selection.

    logic [RCO_NUM_SOURCES-1:0] src_meta_reg;
    logic [RCO_NUM_SOURCES-1:0] src_sync_reg;
    logic                       sel_level;
    logic                       sel_prev_reg;
    logic                       sel_valid;
    logic                       sel_rise;
    logic                       sel_edge;

    // Two flops per source; only the second stage feeds any logic.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            src_meta_reg <= '0;
            src_sync_reg <= '0;
        end else begin
            src_meta_reg <= clock_sources;
            src_sync_reg <= src_meta_reg;
        end
    end

    // Map a source code onto the synchronised vector; gaps read as absent.
    function automatic logic pick_source(input logic [3:0] code,
                                         input logic [RCO_NUM_SOURCES-1:0] vec);
        logic result;
        result = 1'b0;
        if (code >= RCO_SRC_LC_FIRST) begin
            result = vec[4'(code - RCO_SRC_LC_FIRST) + 4'h5]; // R1
        end else if (code <= RCO_SRC_SECONDARY) begin
            result = vec[code]; // R1
        end
        return result;
    endfunction

    // Codes 5 to 7 and the system clock under halt count as no source.
    assign sel_valid = !(src_sel_reg > RCO_SRC_SECONDARY && src_sel_reg < RCO_SRC_LC_FIRST) // R13
                       && !(low_power_halt && src_sel_reg == RCO_SRC_SYSTEM_OSC);          // R9
    assign sel_level = sel_valid && pick_source(src_sel_reg, src_sync_reg);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sel_prev_reg <= 1'b0;
        end else begin
            sel_prev_reg <= sel_level;
        end
    end
    assign sel_rise = sel_level && !sel_prev_reg;
    assign sel_edge = sel_level != sel_prev_reg;

    // ==========================================================================
    // Divider and duty shaping.

    rco_state_e                 state_reg;
    rco_state_e                 state_next;
    logic [7:0]                 half_cnt_reg;
    logic [7:0]                 half_cnt_next;
    logic [7:0]                 period_last;
    logic [7:0]                 high_len;
    logic                       out_next;
    logic                       out_reg;

    // Period in source half cycles is 2^(ratio+1); high part is duty quarters of it.
    assign period_last = 8'((9'h002 << ctrl_reg.ratio) - 9'h001);                   // R5
    assign high_len    = 8'({6'h00, ctrl_reg.duty_select} << (ctrl_reg.ratio - 3'h1)); // R6 R14

    // Start waits for a source rising edge so the first pulse is full length.
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            RCO_IDLE: if (ctrl_reg.enable) state_next = RCO_ARM;
            RCO_ARM:  if (sel_rise) state_next = RCO_RUN;                // R2
            RCO_RUN:  state_next = RCO_RUN;
            default:  state_next = RCO_IDLE;
        endcase
        if (!ctrl_reg.enable) begin
            state_next = RCO_IDLE; // R3
        end
    end

    // Half-cycle counter advances on each source edge and wraps each period.
    always_comb begin
        half_cnt_next = half_cnt_reg;
        if (state_next != RCO_RUN) begin
            half_cnt_next = 8'h00;
        end else if (state_reg == RCO_ARM) begin
            half_cnt_next = 8'h00; // R2
        end else if (sel_edge) begin
            half_cnt_next = (half_cnt_reg >= period_last) ? 8'h00 : 8'(half_cnt_reg + 8'h01); // R14
        end
    end

    // Output level for the coming cycle.
    always_comb begin
        if (state_next != RCO_RUN || !sel_valid || ctrl_reg.duty_select == 2'b00) begin
            out_next = 1'b0; // R3 R13 R7 R6
        end else if (ctrl_reg.ratio == 3'h0) begin
            out_next = sel_level; // R7
        end else begin
            out_next = half_cnt_next < high_len; // R14 R6
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg    <= RCO_IDLE;
            half_cnt_reg <= 8'h00;
        end else begin
            state_reg    <= state_next;
            half_cnt_reg <= half_cnt_next;
        end
    end

    // Pin driver and enable are flopped on the same edge so both stop in the same cycle.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            out_reg               <= 1'b0;
            reference_output_oe_n <= 1'b1;
        end else begin
            out_reg               <= out_next;
            reference_output_oe_n <= !ctrl_reg.enable; // R3
        end
    end

    // Internal copy for the modulator, memory scanner and timers.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reference_clock_internal <= 1'b0;
        end else begin
            reference_clock_internal <= out_next; // R10
        end
    end

    assign reference_output_pin = out_reg;

endmodule // rco_top

// *** dv/rco_checker.sv ***
// Checker for the reference clock output block.
// Assumes it is bound to rco_top and sees only its ports.
`timescale 1ns/100ps
module rco_checker
    import rco_pkg::*;
(
    // Clock, reset and bus.
    input wire logic        clock,
    input wire logic        rstn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Power state and outputs.
    input wire logic        low_power_halt,
    input wire logic        reference_output_pin,
    input wire logic        reference_output_oe_n,
    input wire logic        reference_clock_internal
);
    logic       en_q;
    logic [1:0] duty_q;
    logic [2:0] ratio_q;
    logic [3:0] src_q;
    wire        wr_ok  = psel && penable && pready && pwrite;
    wire        mapped = paddr == RCO_CTRL_ADDR || paddr == RCO_SRCSEL_ADDR;
    // ==========================================================
    // Shadow registers, so that outputs can be tied to their settings.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            {en_q, duty_q, ratio_q} <= {RCO_EN_RST, RCO_DUTY_RST, RCO_RATIO_RST};
            src_q                   <= RCO_SRC_RST;
        end else if (wr_ok && paddr == RCO_CTRL_ADDR) begin
            {en_q, duty_q, ratio_q} <= {pwdata[7], pwdata[4:3], pwdata[2:0]};
        end else if (wr_ok && paddr == RCO_SRCSEL_ADDR) begin
            src_q                   <= pwdata[3:0];
        end
    end
    // ==========================================================
    // Properties share one clock and the bus reset.
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    AST_PREADY_NEXT: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    AST_SLVERR: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr wrong for address");
    AST_READ_CTRL: assert property (pready && !pwrite && paddr == RCO_CTRL_ADDR
        |-> prdata == {24'h0, en_q, 2'h0, duty_q, ratio_q}) else $error("control read wrong");
    AST_READ_SRC: assert property (pready && !pwrite && paddr == RCO_SRCSEL_ADDR
        |-> prdata == {28'h0, src_q}) else $error("source read wrong");
    AST_INTERNAL: assert property (reference_clock_internal == reference_output_pin)
        else $error("internal clock differs from pin");
    AST_OFF_LOW: assert property (!en_q && !$past(en_q) |-> !reference_output_pin && reference_output_oe_n)
        else $error("output active while disabled");
    AST_DUTY_ZERO: assert property (duty_q == 2'h0 |-> !reference_output_pin)
        else $error("output high with zero duty");
    AST_BAD_SRC: assert property (src_q inside {[4'h5:4'h7]} |-> !reference_output_pin)
        else $error("output high with absent source");
    AST_HALT_SYS: assert property (low_power_halt && $past(low_power_halt) && src_q == 4'h0
        |-> !reference_output_pin) else $error("output runs in halt on system clock");
    AST_EN_DRIVE: assert property ($rose(en_q) |-> ##[1:8] !reference_output_oe_n)
        else $error("pin not driven after enable");
endmodule // rco_checker

bind rco_top rco_checker u_chk (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .low_power_halt(low_power_halt), .reference_output_pin(reference_output_pin),
    .reference_output_oe_n(reference_output_oe_n), .reference_clock_internal(reference_clock_internal));

// *** dv/rco_src_model.sv ***
// Model of the oscillators and logic cells feeding the block.
// Assumes the 25 MHz bench clock; source i has a half period of 4+i cycles.
`timescale 1ns/100ps
module rco_src_model
    import rco_pkg::*;
(
    // Bench clock and halt state.
    input  wire logic        clock,
    input  wire logic        low_power_halt,
    // Source clocks to the block.
    output rco_pkg::rco_src_s clock_sources
);
    int          tick  = 0;
    int          tick0 = 0;
    logic [12:0] bits;
    // The system oscillator stops in halt; the others run free.
    always @(posedge clock) begin
        tick <= tick + 1;
        if (!low_power_halt) tick0 <= tick0 + 1;
    end
    // Bit order follows the source codes, cells from bit five.
    always_comb begin
        for (int i = 1; i < RCO_NUM_SOURCES; i++) bits[i] = ((tick / (4 + i)) % 2) == 1;
        bits[0] = ((tick0 / 4) % 2) == 1;
    end
    assign clock_sources = bits;
endmodule // rco_src_model

// *** dv/reference_clock_output_tb.sv ***
// Testbench for the reference clock output block: registers and output waveform.
// Assumes rco_top, the source model and the bound checker.
`timescale 1ns/100ps
module reference_clock_output_tb;
    import rco_pkg::*;
    logic        clock = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err, pin, oe_n, internal, low_power_halt = 1'b0;
    rco_src_s    clock_sources;
    int          miscompares = 0, checks_done = 0, seed = 32'h1F0F316E, ctrl_m = 32'h10, src_m = 0;
    rco_top u_dut (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .clock_sources(clock_sources), .low_power_halt(low_power_halt), .reference_output_pin(pin),
        .reference_output_oe_n(oe_n), .reference_clock_internal(internal));
    rco_src_model u_src (.clock(clock), .low_power_halt(low_power_halt), .clock_sources(clock_sources));
    always #20 clock = ~clock;
    // ==========================================================
    task automatic chk_reg(input string name, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %0h seen %0h", name, e, g);
        end
    endtask
    task automatic chk_cnt(input string name, input int e, input int g);
        checks_done++;
        if (g != e) begin
            miscompares++;
            $display("ERROR %s expected %0d seen %0d", name, e, g);
        end
    endtask
    // One APB transfer; the request stands until pready is seen.
    task automatic reg_op(input logic wr, input logic [15:0] a, input logic [31:0] d);
        @(posedge clock);
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
        @(posedge clock);
        penable <= 1'b1;
        // Only the watchdog ends this wait; the master assumes no answer time.
        do @(posedge clock); while (pready !== 1'b1);
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
        if (wr && a == RCO_CTRL_ADDR) ctrl_m = d & 32'h9F;
        if (wr && a == RCO_SRCSEL_ADDR) src_m = d & 32'h0F;
        chk_reg("pslverr", 32'(a != RCO_CTRL_ADDR && a != RCO_SRCSEL_ADDR), 32'(err));
        if (!wr) chk_reg("prdata", a == RCO_CTRL_ADDR ? ctrl_m : a == RCO_SRCSEL_ADDR ? src_m : 0, rd);
    endtask
    // Configure while disabled, enable, check the first full pulse, disable.
    task automatic trial(input int s, input int r, input int d);
        int h, p, half, eh, ep;
        {h, p} = 0;
        half = 4 + ((s <= 4) ? s : s - 3);
        ep = (2 * half) << r;
        reg_op(1'b1, RCO_SRCSEL_ADDR, 32'(s));
        reg_op(1'b1, RCO_CTRL_ADDR, 32'(d * 8 + r));
        reg_op(1'b0, RCO_CTRL_ADDR, 32'h0);
        // Halt may be raised just before the call, so it is judged only once it has landed.
        eh = (s inside {[5:7]} || d == 0 || (s == 0 && low_power_halt)) ? 0 : (r == 0) ? half : d * ep / 4;
        // Enable last, so that the watch below starts before any pulse can begin.
        reg_op(1'b1, RCO_CTRL_ADDR, 32'(128 + d * 8 + r));
        if (eh == 0) begin
            repeat (2 * ep) @(posedge clock) h += int'(pin === 1'b1);
            chk_cnt("high cycles", 0, h);
        end else begin
            while (pin !== 1'b1 && p++ < 3000) @(posedge clock);
            while (pin === 1'b1 && h < 3000) @(posedge clock) h++;
            p = h;
            while (pin !== 1'b1 && p < 6000) @(posedge clock) p++;
            chk_cnt("high cycles", eh, h);
            chk_cnt("period", ep, p);
        end
        chk_cnt("driven while enabled", 1, int'(oe_n === 1'b0 && internal === pin));
        reg_op(1'b1, RCO_CTRL_ADDR, 32'(d * 8 + r));
        repeat (2) @(posedge clock);
        chk_cnt("pin after disable", 1, int'(pin === 1'b0 && oe_n === 1'b1 && internal === 1'b0));
        $display("test source %0d ratio %0d duty %0d done", s, r, d);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ==========================================================
    initial begin
        repeat (5) @(posedge clock);
        rstn <= 1'b1;
        repeat (3) @(posedge clock);
        reg_op(1'b0, RCO_CTRL_ADDR, 32'h0);
        reg_op(1'b0, RCO_SRCSEL_ADDR, 32'h0);
        reg_op(1'b1, RCO_CTRL_ADDR, 32'hFFFFFF7F);
        reg_op(1'b1, RCO_SRCSEL_ADDR, 32'hFFFFFFF5);
        reg_op(1'b1, 16'(($random(seed) & 32'hFF) * 4), 32'hFFFFFFFF);
        reg_op(1'b0, 16'h0FFC, 32'h0);
        reg_op(1'b0, RCO_CTRL_ADDR, 32'h0);
        reg_op(1'b0, RCO_SRCSEL_ADDR, 32'h0);
        $display("register test done");
        for (int s = 0; s < 16; s++) trial(s, (s == 1) ? 7 : $unsigned($random(seed)) % 7, s % 4);
        trial(9, 0, 1);
        low_power_halt <= 1'b1;
        trial(0, 1, 2);
        trial(2, 1, 2);
        complete_run();
    end
    // A hang counts as a mismatch and ends the run.
    initial begin
        repeat (95000) @(posedge clock);
        miscompares++;
        complete_run();
    end
endmodule // reference_clock_output_tb
